/* File: bench/clock_tick_timer_tb.sv */
`timescale 1ns/1ns
module clock_tick_timer_tb import tti_pkg::*;;

  localparam int TDIV = 16;
  localparam int HLEN = 30;

  logic             clk_sys;
  logic             reset;
  tti_axil_req_type axiReq;
  tti_axil_rsp_type axiRsp;
  logic             irqReq;
  int               failures;
  int               checks;
  logic [3:0]       v;
  logic [1:0]       rsp;
  bit               tmo;
  logic [7:0]       c0;
  logic [7:0]       c1;

  // ==========================================================
  // clock and instances
  always #50 clk_sys = ~clk_sys;

  clock_tick_timer #(.TICK_DIV(TDIV), .HOLD_LEN(HLEN)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .axiReq(axiReq), .axiRsp(axiRsp), .irqReq(irqReq));

  tti_cpu_model i_cpu (.clk_sys(clk_sys), .axiRsp(axiRsp), .axiReq(axiReq));

  // ==========================================================
  // checking and bus helpers
  task automatic end_sim();
    if (failures == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
    chk({4'h0, got}, {4'h0, exp});
  endtask : chk4

  task automatic chkr(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    checks++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: got %h, outside %h..%h", $time, got, lo, hi);
    end
  endtask : chkr

  task automatic hang();
    failures++;
    $display("wrong value at %0t: bus answer missing", $time);
    end_sim();
  endtask : hang

  task automatic rdr(input logic [15:0] idx, output logic [3:0] d);
    i_cpu.rd(idx, d, rsp, tmo);
    if (tmo) hang();
  endtask : rdr

  task automatic wrr(input logic [15:0] idx, input logic [3:0] d);
    i_cpu.wr(idx, d, rsp, tmo);
    if (tmo) hang();
  endtask : wrr

  // low nibble first so the high nibble is held
  task automatic rdcnt(output logic [7:0] c);
    rdr(IDX_LOW, c[3:0]);
    rdr(IDX_HIGH, c[7:4]);
  endtask : rdcnt

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic chkirq(input logic exp);
    cyc(2);
    chk({7'h0, irqReq}, {7'h0, exp});
  endtask : chkirq

  // catch low at f with a known high, then read high after a gap
  task automatic holdCase(input int gap, input logic [3:0] inc);
    logic [3:0] l;
    logic [3:0] h;
    logic [3:0] hx;
    bit         have;
    int         n;
    have = 0;
    n = 0;
    l = 4'h0;
    while (!(have && l == 4'hf) && n < 200) begin
      rdr(IDX_LOW, l);
      if (l < 4'hd) begin
        rdr(IDX_HIGH, h);
        have = 1;
      end
      n++;
    end
    if (n >= 200) hang();
    cyc(gap);
    rdr(IDX_HIGH, hx);
    chk4(hx, h + inc);
    rdr(IDX_HIGH, hx);
    chk4(hx, h + 4'h1);
  endtask : holdCase

  // ==========================================================
  // main sequence
  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    failures = 0;
    checks = 0;
    cyc(2);
    reset <= 1'b0;
    // reset values, unmapped place, read-only and read/write places
    rdr(IDX_CTRL, v); chk4(v, 4'h0);
    rdr(IDX_LOW, v); chk4(v, 4'h0);
    rdr(IDX_HIGH, v); chk4(v, 4'h0);
    rdr(IDX_IEN, v); chk4(v, 4'h0);
    rdr(IDX_FLAG, v); chk4(v, 4'h0);
    rdr(16'hff7b, v);
    chk4({2'h0, rsp}, {2'h0, RESP_SLVERR});
    wrr(IDX_HIGH, 4'h5); rdr(IDX_HIGH, v); chk4(v, 4'h0);
    wrr(IDX_IEN, 4'ha); rdr(IDX_IEN, v); chk4(v, 4'ha);
    wrr(IDX_IEN, 4'h0);
    // clear and run together; clear bit reads back zero
    wrr(IDX_CTRL, 4'h3); rdr(IDX_CTRL, v); chk4(v, 4'h1);
    cyc(TDIV * 20);
    rdr(IDX_FLAG, v); chk4(v, 4'h1);
    rdcnt(c0); chkr(c0, 8'd19, 8'd22);
    cyc(TDIV * 20);
    rdr(IDX_FLAG, v); chk4(v, 4'h3);
    cyc(TDIV * 240);
    rdr(IDX_FLAG, v); chk4(v, 4'hf);
    chkirq(1'b0);
    // stop holds, run resumes from the held value
    wrr(IDX_CTRL, 4'h0); rdcnt(c0);
    cyc(100);
    rdcnt(c1); chk(c1, c0);
    wrr(IDX_CTRL, 4'h1); cyc(TDIV * 4); wrr(IDX_CTRL, 4'h0);
    rdcnt(c1); chkr(c1, c0 + 8'd3, c0 + 8'd5);
    // clear while stopped keeps zero
    wrr(IDX_CTRL, 4'h2); rdcnt(c1); chk(c1, 8'h00);
    cyc(100);
    rdcnt(c1); chk(c1, 8'h00);
    rdr(IDX_CTRL, v); chk4(v, 4'h0);
    // flag clearing and request masking
    wrr(IDX_FLAG, 4'h0); rdr(IDX_FLAG, v); chk4(v, 4'hf);
    wrr(IDX_IEN, 4'h1); chkirq(1'b1);
    wrr(IDX_FLAG, 4'h1); rdr(IDX_FLAG, v); chk4(v, 4'he);
    chkirq(1'b0);
    wrr(IDX_IEN, 4'h8); chkirq(1'b1);
    wrr(IDX_FLAG, 4'he); rdr(IDX_FLAG, v); chk4(v, 4'h0);
    chkirq(1'b0);
    // clear while running restarts at once
    wrr(IDX_CTRL, 4'h1); cyc(TDIV * 10);
    wrr(IDX_CTRL, 4'h3); rdcnt(c1); chkr(c1, 8'd0, 8'd1);
    cyc(TDIV * 5);
    rdcnt(c1); chkr(c1, 8'd4, 8'd6);
    // high nibble hold: released by high read, then by window end
    holdCase(18, 4'h0);
    holdCase(HLEN + 15, 4'h1);
    end_sim();
  end

endmodule : clock_tick_timer_tb

/* File: bench/tti_cpu_model.sv */
`timescale 1ns/1ns
// ==========================================================
// cpu core stand-in: bus master on the register bus
module tti_cpu_model import tti_pkg::*; (
  input  wire logic             clk_sys,
  input  wire tti_axil_rsp_type axiRsp,
  output tti_axil_req_type      axiReq
);

  // idle bus from time zero
  initial axiReq = '0;

  // one write; address and data offered together, each dropped once taken
  task automatic wr(input logic [15:0] idx, input logic [3:0] d, output logic [1:0] resp,
                    output bit tmo);
    int n;
    n = 0;
    @(posedge clk_sys);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr  <= {idx, 2'b00};
    axiReq.wvalid  <= 1'b1;
    axiReq.wdata   <= {28'h0, d};
    axiReq.wstrb   <= 4'hf;
    axiReq.bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
    end while (!(axiRsp.bvalid && axiReq.bready) && n < 50);
    axiReq.bready <= 1'b0;
    resp = axiRsp.bresp;
    tmo = (axiRsp.bvalid !== 1'b1);
  endtask : wr

  // one read; data taken at the edge where rvalid is seen
  task automatic rd(input logic [15:0] idx, output logic [3:0] d, output logic [1:0] resp,
                    output bit tmo);
    int n;
    n = 0;
    @(posedge clk_sys);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr  <= {idx, 2'b00};
    axiReq.rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
    end while (!(axiRsp.rvalid && axiReq.rready) && n < 50);
    axiReq.rready <= 1'b0;
    d = axiRsp.rdata[3:0];
    resp = axiRsp.rresp;
    tmo = (axiRsp.rvalid !== 1'b1);
  endtask : rd

endmodule : tti_cpu_model

/* File: src/clock_tick_timer.sv */
// Behaviour
// - eight-bit binary up counter advanced by a divided-down slow tick
// - low nibble holds 128..16 Hz taps, high nibble 8..1 Hz taps
// - low read blocks high carries until high read or hold window ends
// - falling edges of 16, 8, 2 and 1 Hz taps are interrupt events
// - each such edge sets its flag regardless of the enable bit
// - four read/write enable bits, one enables, reset to zero
// - control bit 1 write-one clears counter, reads back zero
// - counter bits are read-only and reset to zero
// - control bit 0 runs counting; zero stops and holds; resets to zero
// - clear while running restarts at once; while stopped holds zero
// - flag cleared only by writing one; zero ignored; reset to zero
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
module clock_tick_timer import tti_pkg::*; #(
  parameter int TICK_DIV = TICK_DIV_CYC,
  parameter int HOLD_LEN = HOLD_CYC
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire tti_axil_req_type axiReq,
  output tti_axil_rsp_type      axiRsp,
  output logic                  irqReq
);

  localparam int HW = $clog2(HOLD_LEN + 1);

  typedef struct packed {
    logic [7:0]    cnt;
    logic          run;
    logic [3:0]    ien;
    logic [3:0]    flag;
    logic          hold;
    logic [HW-1:0] holdCnt;
    logic          carryPend;
    logic          irq;
  } tti_state_type;

  tti_state_type  s_q;
  tti_state_type  s_d;
  tti_regacc_type acc;
  logic [3:0]     rdData;
  logic           tick;
  logic           wrCtrl;
  logic           wrIen;
  logic           wrFlag;
  logic           clrCnt;
  logic           rdLow;
  logic           rdHigh;
  logic           advance;
  logic           holdOn;
  logic [3:0]     fallSet;
  logic [3:0]     lowNext;
  logic [3:0]     highNext;
  logic           carry;

  // ==========================================================
  // bus slave and count-rate divider
  tti_axil_slave u_slave (
    .clk_sys (clk_sys),
    .reset   (reset),
    .axiReq  (axiReq),
    .axiRsp  (axiRsp),
    .acc     (acc),
    .rdData  (rdData)
  );

  tti_tick_gen #(
    .DIV (TICK_DIV)
  ) u_tick (
    .clk_sys (clk_sys),
    .reset   (reset),
    .restart (clrCnt),
    .tick    (tick)
  );

  // ==========================================================
  // access decode
  assign wrCtrl  = acc.wrEn && (acc.wrIdx == IDX_CTRL);
  assign wrIen   = acc.wrEn && (acc.wrIdx == IDX_IEN);
  assign wrFlag  = acc.wrEn && (acc.wrIdx == IDX_FLAG);
  assign clrCnt  = wrCtrl && acc.wrData[CTRL_CLR_POS];
  assign rdLow   = acc.rdEn && (acc.rdIdx == IDX_LOW);
  assign rdHigh  = acc.rdEn && (acc.rdIdx == IDX_HIGH);
  assign advance = s_q.run && tick;
  assign holdOn  = s_q.hold && !rdHigh && (s_q.holdCnt != '0);

  // ==========================================================
  // read mux; clear bit and upper bits read as zero
  always_comb begin
    rdData = 4'h0;
    unique case (acc.rdIdx)
      IDX_CTRL: rdData = {3'b000, s_q.run};
      IDX_LOW:  rdData = s_q.cnt[3:0];
      IDX_HIGH: rdData = s_q.cnt[7:4];
      IDX_IEN:  rdData = s_q.ien;
      IDX_FLAG: rdData = s_q.flag;
      default:  rdData = 4'h0;
    endcase
  end

  // ==========================================================
  // counter, hold, flags and request
  always_comb begin
    s_d      = s_q;
    lowNext  = s_q.cnt[3:0];
    highNext = s_q.cnt[7:4];
    carry    = 1'b0;
    fallSet  = 4'h0;
    // hold window countdown and release
    s_d.hold = holdOn;
    if (holdOn) s_d.holdCnt = s_q.holdCnt - HW'(1);
    if (s_q.hold && !holdOn && s_q.carryPend) begin
      highNext      = highNext + 4'h1;                         // deferred carry
      s_d.carryPend = 1'b0;
    end
    // count step
    if (advance) begin
      lowNext = s_q.cnt[3:0] + 4'h1;
      carry   = (s_q.cnt[3:0] == 4'hf);
      if (carry && holdOn) s_d.carryPend = 1'b1;
      else if (carry) highNext = highNext + 4'h1;
    end
    s_d.cnt = {highNext, lowNext};
    // a low read opens the hold window
    if (rdLow) begin
      s_d.hold    = 1'b1;
      s_d.holdCnt = HW'(HOLD_LEN - 1);
    end
    // control writes; clear wins over a step
    if (wrCtrl) s_d.run = acc.wrData[CTRL_RUN_POS];
    if (clrCnt) begin
      s_d.cnt       = CNT_RST;
      s_d.carryPend = 1'b0;
    end else begin
      fallSet = {s_q.cnt[TAP_1HZ_POS] & ~s_d.cnt[TAP_1HZ_POS],
                 s_q.cnt[TAP_2HZ_POS] & ~s_d.cnt[TAP_2HZ_POS],
                 s_q.cnt[TAP_8HZ_POS] & ~s_d.cnt[TAP_8HZ_POS],
                 s_q.cnt[TAP_16HZ_POS] & ~s_d.cnt[TAP_16HZ_POS]};
    end
    if (wrIen) s_d.ien = acc.wrData;
    // write-one clears, a same-cycle edge wins
    if (wrFlag) s_d.flag = s_q.flag & ~acc.wrData;
    s_d.flag = s_d.flag | fallSet;
    s_d.irq  = |(s_d.flag & s_d.ien);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q      <= '0;
      s_q.cnt  <= CNT_RST;
      s_q.run  <= RUN_RST;
      s_q.ien  <= IEN_RST;
      s_q.flag <= FLAG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign irqReq = s_q.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_clear_zero: assert property (clrCnt |=> s_q.cnt == 8'h00)
    else $error("counter not cleared by control write");

  a_clear_readback: assert property (
    acc.rdEn && acc.rdIdx == IDX_CTRL |-> rdData[CTRL_CLR_POS] == 1'b0)
    else $error("clear bit read back as one");

  a_stop_holds: assert property (
    !s_q.run && !clrCnt && !(s_q.hold && s_q.carryPend) |=> $stable(s_q.cnt))
    else $error("count moved while stopped");

  a_run_steps: assert property (
    advance && !clrCnt |=> s_q.cnt[3:0] == $past(s_q.cnt[3:0]) + 4'h1)
    else $error("low nibble did not step");

  a_hold_blocks: assert property (
    holdOn && !clrCnt && !(s_q.hold && s_q.carryPend) |=> $stable(s_q.cnt[7:4]))
    else $error("high nibble moved during hold");

  a_hold_ends: assert property (
    s_q.hold && s_q.holdCnt == '0 && !rdLow |=> !s_q.hold)
    else $error("hold window overran");

  a_high_read_ends: assert property (
    s_q.hold && rdHigh && !rdLow |=> !s_q.hold)
    else $error("hold not released by high read");

  a_flag_set: assert property (
    fallSet[0] |=> s_q.flag[0] ##1 (s_q.flag[0] || $past(wrFlag && acc.wrData[0])))
    else $error("16 Hz flag not set on falling tap");

  a_flag_keep: assert property (
    s_q.flag[1] && !(wrFlag && acc.wrData[1]) |=> s_q.flag[1])
    else $error("8 Hz flag lost without write one");

  a_irq_out: assert property (
    (|(s_q.flag & s_q.ien)) |-> irqReq || $past(wrFlag || wrIen))
    else $error("request missing for enabled flag");

  a_reset_vals: assert property ($fell(reset) |->
    s_q.ien == 4'h0 && s_q.flag == 4'h0 && !s_q.run && s_q.cnt == 8'h00)
    else $error("wrong state after reset");

  // ==========================================================
  // falling taps set their flags, whatever the enables say
  a_edge_16hz: assert property (
    $fell(s_q.cnt[TAP_16HZ_POS]) && !$past(clrCnt) |-> s_q.flag[0])
    else $error("16 Hz falling tap left flag clear");

  a_edge_8hz: assert property (
    $fell(s_q.cnt[TAP_8HZ_POS]) && !$past(clrCnt) |-> s_q.flag[1])
    else $error("8 Hz falling tap left flag clear");

  a_edge_2hz: assert property (
    $fell(s_q.cnt[TAP_2HZ_POS]) && !$past(clrCnt) |-> s_q.flag[2])
    else $error("2 Hz falling tap left flag clear");

  a_edge_1hz: assert property (
    $fell(s_q.cnt[TAP_1HZ_POS]) && !$past(clrCnt) |-> s_q.flag[3])
    else $error("1 Hz falling tap left flag clear");

  a_flag_set_8: assert property (fallSet[1] |=> s_q.flag[1])
    else $error("8 Hz flag not set on falling tap");

  a_flag_set_2: assert property (fallSet[2] |=> s_q.flag[2])
    else $error("2 Hz flag not set on falling tap");

  a_flag_set_1: assert property (fallSet[3] |=> s_q.flag[3])
    else $error("1 Hz flag not set on falling tap");

  // ==========================================================
  // flags only drop on a write of one
  a_flag_keep_16: assert property (
    s_q.flag[0] && !(wrFlag && acc.wrData[0]) |=> s_q.flag[0])
    else $error("16 Hz flag lost without write one");

  a_flag_keep_2: assert property (
    s_q.flag[2] && !(wrFlag && acc.wrData[2]) |=> s_q.flag[2])
    else $error("2 Hz flag lost without write one");

  a_flag_keep_1: assert property (
    s_q.flag[3] && !(wrFlag && acc.wrData[3]) |=> s_q.flag[3])
    else $error("1 Hz flag lost without write one");

  a_flag_clear: assert property (
    wrFlag && acc.wrData[0] && !fallSet[0] |=> !s_q.flag[0])
    else $error("16 Hz flag not cleared by write one");

  a_clear_flags: assert property (clrCnt |=> $stable(s_q.flag))
    else $error("counter clear touched the flags");

  // ==========================================================
  // control and enable registers, and the request output
  a_ien_write: assert property (wrIen |=> s_q.ien == $past(acc.wrData))
    else $error("enable write not stored");

  a_ien_keep: assert property (!wrIen |=> $stable(s_q.ien))
    else $error("enables changed without write");

  a_run_write: assert property (
    wrCtrl |=> s_q.run == $past(acc.wrData[CTRL_RUN_POS]))
    else $error("run bit write not stored");

  a_run_keep: assert property (!wrCtrl |=> $stable(s_q.run))
    else $error("run bit changed without write");

  a_irq_match: assert property (irqReq == |(s_q.flag & s_q.ien))
    else $error("request differs from enabled flags");

  // ==========================================================
  // carries and the hold window
  a_high_steps: assert property (
    !s_q.hold && advance && !clrCnt && s_q.cnt[3:0] == 4'hf
    |=> s_q.cnt[7:4] == $past(s_q.cnt[7:4]) + 4'h1)
    else $error("carry into high nibble lost");

  a_low_arms: assert property (rdLow |=> s_q.hold)
    else $error("low read did not open hold");

  a_hold_count: assert property (
    holdOn && !rdLow |=> s_q.holdCnt == $past(s_q.holdCnt) - HW'(1))
    else $error("hold window not counting down");

  a_clear_pend: assert property (clrCnt |=> !s_q.carryPend)
    else $error("deferred carry survived a clear");

  // main scenarios reached
  c_carry_held: cover property (s_q.hold && s_q.carryPend);
  c_high_rel:   cover property (s_q.hold && rdHigh);
  c_flag_wr:    cover property (wrFlag && acc.wrData != 4'h0);
  c_irq_1hz:    cover property (fallSet[3] && s_q.ien[3]);
  c_clear_stop: cover property (clrCnt && !s_q.run);

endmodule : clock_tick_timer

/* File: src/tti_axil_slave.sv */
`timescale 1ns/1ns
module tti_axil_slave import tti_pkg::*; (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire tti_axil_req_type  axiReq,
  output tti_axil_rsp_type       axiRsp,
  output tti_regacc_type         acc,
  input  wire logic [3:0]        rdData
);

  typedef struct packed {
    logic              awHave;
    logic              wHave;
    logic [ADDR_W-1:0] addr;
    logic [3:0]        data;
    logic              strb0;
    tti_axil_rsp_type  rsp;
  } tti_slv_type;

  tti_slv_type s_q;
  tti_slv_type s_d;
  logic        doWrite;
  logic        doRead;

  assign doWrite = s_q.awHave && s_q.wHave && !s_q.rsp.bvalid;
  assign doRead  = axiReq.arvalid && s_q.rsp.arready;

  // ==========================================================
  // write path: address and data in either order, then response
  always_comb begin
    s_d = s_q;
    if (axiReq.awvalid && s_q.rsp.awready) begin
      s_d.awHave = 1'b1;
      s_d.addr   = axiReq.awaddr;
    end
    if (axiReq.wvalid && s_q.rsp.wready) begin
      s_d.wHave = 1'b1;
      s_d.data  = axiReq.wdata[3:0];
      s_d.strb0 = axiReq.wstrb[0];
    end
    if (doWrite) begin
      s_d.awHave     = 1'b0;
      s_d.wHave      = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp  = tti_mapped(tti_index(s_q.addr)) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.rsp.bvalid && axiReq.bready) begin
      s_d.rsp.bvalid = 1'b0;
    end
    s_d.rsp.awready = !s_d.awHave && !s_d.rsp.bvalid;
    s_d.rsp.wready  = !s_d.wHave && !s_d.rsp.bvalid;
    // read path: data captured on the address handshake
    if (doRead) begin
      s_d.rsp.arready = 1'b0;
      s_d.rsp.rvalid  = 1'b1;
      s_d.rsp.rdata   = {28'h0000000, rdData};
      s_d.rsp.rresp   = tti_mapped(tti_index(axiReq.araddr)) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.rsp.rvalid && axiReq.rready) begin
      s_d.rsp.rvalid  = 1'b0;
      s_d.rsp.arready = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q             <= '0;
      s_q.rsp.awready <= 1'b1;
      s_q.rsp.wready  <= 1'b1;
      s_q.rsp.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // strobes to the timer; byte lane 0 must be enabled to write
  assign axiRsp     = s_q.rsp;
  assign acc.wrEn   = doWrite && s_q.strb0;
  assign acc.wrIdx  = tti_index(s_q.addr);
  assign acc.wrData = s_q.data;
  assign acc.rdEn   = doRead;
  assign acc.rdIdx  = tti_index(axiReq.araddr);

endmodule : tti_axil_slave

/* File: src/tti_pkg.sv */
package tti_pkg;

  // ==========================================================
  // register map (indices; byte address is four times the index)
  localparam int               ADDR_W   = 18;
  localparam logic [15:0]      IDX_CTRL = 16'hff78;
  localparam logic [15:0]      IDX_LOW  = 16'hff79;
  localparam logic [15:0]      IDX_HIGH = 16'hff7a;
  localparam logic [15:0]      IDX_IEN  = 16'hffe6;
  localparam logic [15:0]      IDX_FLAG = 16'hfff6;

  // ==========================================================
  // field positions
  localparam int               CTRL_RUN_POS = 0;   // count_run_bit
  localparam int               CTRL_CLR_POS = 1;   // count_clear_bit
  localparam int               TAP_16HZ_POS = 3;
  localparam int               TAP_8HZ_POS  = 4;
  localparam int               TAP_2HZ_POS  = 6;
  localparam int               TAP_1HZ_POS  = 7;

  // ==========================================================
  // reset values
  localparam logic [7:0]       CNT_RST  = 8'h00;
  localparam logic [3:0]       IEN_RST  = 4'h0;
  localparam logic [3:0]       FLAG_RST = 4'h0;
  localparam logic             RUN_RST  = 1'b0;

  // ==========================================================
  // timing: count rate is twice the 128 Hz tap
  localparam int               CLK_HZ       = 10_000_000;
  localparam int               COUNT_HZ     = 256;
  localparam int               TICK_DIV_CYC = CLK_HZ / COUNT_HZ;
  localparam int               HOLD_TIME_US = 1000;
  localparam int               HOLD_CYC     = HOLD_TIME_US * (CLK_HZ / 1_000_000);

  // ==========================================================
  // bus answers
  localparam logic [1:0]       RESP_OKAY   = 2'h0;
  localparam logic [1:0]       RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } tti_axil_req_type;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } tti_axil_rsp_type;

  // register access strobes between bus slave and timer
  typedef struct packed {
    logic              wrEn;
    logic [15:0]       wrIdx;
    logic [3:0]        wrData;
    logic              rdEn;
    logic [15:0]       rdIdx;
  } tti_regacc_type;

  // maps a byte address onto a register index
  function automatic logic [15:0] tti_index(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction : tti_index

  // true for an index that holds a register
  function automatic logic tti_mapped(input logic [15:0] idx);
    return (idx == IDX_CTRL) || (idx == IDX_LOW) || (idx == IDX_HIGH) ||
           (idx == IDX_IEN) || (idx == IDX_FLAG);
  endfunction : tti_mapped

endpackage : tti_pkg

/* File: src/tti_tick_gen.sv */
`timescale 1ns/1ns
module tti_tick_gen import tti_pkg::*; #(
  parameter int DIV = TICK_DIV_CYC
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic restart,
  output logic      tick
);

  localparam int W = $clog2(DIV + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } tti_div_type;

  tti_div_type s_q;
  tti_div_type s_d;

  // ==========================================================
  // divider: one pulse per DIV cycles, phase restarts on request
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (restart) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == W'(DIV - 1)) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) s_q <= '0;
    else       s_q <= s_d;
  end

  assign tick = s_q.tick;

endmodule : tti_tick_gen
